// ---- lpc_pkg.sv ----
/*
  Shared constants and types of the loopback path control block: register
  addresses, field positions, reset values, qualification timing, carriers.
  Assumes a 32-bit AXI4-Lite register bus and a single 250 MHz clock.
*/
package lpc_pkg;

  // ==========
  // Register map
  // ==========
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_INDEX = 8'h05;
  localparam logic [7:0] CTRL_ADDR = {CTRL_INDEX[5:0], 2'b00};
  localparam logic [7:0] IRQ_STS_ADDR = 8'h20;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h24;
  localparam logic [7:0] RX_INFO2_ADDR = 8'h28;

  // ==========
  // Control register fields
  // ==========
  localparam int LOCAL_LOOP_BIT = 7;
  localparam int REMOTE_LOOP_BIT = 6;
  localparam int AUTO_LOOP_BIT = 5;
  localparam int ANALOG_LOOP_BIT = 4;
  localparam int JA_BYPASS_BIT = 3;
  localparam int ERR_SEL_MSB = 2;
  localparam int ERR_SEL_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========
  // Event, info and interrupt fields
  // ==========
  localparam int EVT_W = 2;
  localparam int EVT_ENTER_BIT = 0;
  localparam int EVT_EXIT_BIT = 1;
  localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
  localparam int INFO2_EFF_REMOTE_BIT = 0;
  localparam int INFO2_AUTO_LOOP_BIT = 1;

  // ==========
  // Timing
  // ==========
  localparam longint unsigned CLK_HZ = 250_000_000;
  localparam longint unsigned QUAL_TIME_S = 5;
  localparam int unsigned QUAL_CYCLES_DEF = 32'(QUAL_TIME_S * CLK_HZ);

  // ==========
  // Bus responses
  // ==========
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========
  // Types
  // ==========
  typedef struct packed {
    logic pos;
    logic neg;
  } lpc_pair_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } lpc_wr_type;

  typedef enum logic [1:0] {
    LPC_AUTO_IDLE = 2'b01,
    LPC_AUTO_LOOPED = 2'b10
  } lpc_auto_state_type;

endpackage

// ---- lpc_qual_timer.sv ----
/*
  Qualification timer: pulses once after its detect input has been high for
  QUAL_CYCLES consecutive clock cycles.
  Assumes detect is synchronous to aclk.
*/
module lpc_qual_timer #(
  parameter int unsigned QUAL_CYCLES = lpc_pkg::QUAL_CYCLES_DEF,
  parameter int CNT_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic detect,
  output logic qualified
);

  logic [CNT_W-1:0] cnt_q;

  // Any gap in detection restarts the count
  always_ff @(posedge aclk) begin
    if (!aresetn || clear || !detect) begin
      cnt_q <= '0;
    end else if (cnt_q != CNT_W'(QUAL_CYCLES)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qualified <= 1'b0;
    end else begin
      qualified <= !clear && detect && (cnt_q == CNT_W'(QUAL_CYCLES - 1));
    end
  end

endmodule // lpc_qual_timer

// ---- lpc_axil_port.sv ----
/*
  AXI4-Lite slave handshake: takes address and data in either order, hands a
  single write or read to the register file, returns registered responses.
  Assumes the register file decodes combinationally in the same cycle.
*/
module lpc_axil_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [lpc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lpc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic wr_en,
  output lpc_pkg::lpc_wr_type wr,
  input wire logic wr_ok,
  output logic [lpc_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  logic aw_have_q;
  logic w_have_q;
  logic ar_have_q;

  assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;

  // ==========
  // Write channels
  // ==========
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lpc_pkg::RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      wr <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr.addr <= s_axi_awaddr;
        aw_have_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr.data <= s_axi_wdata;
        wr.strb <= s_axi_wstrb;
        w_have_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? lpc_pkg::RESP_OKAY : lpc_pkg::RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========
  // Read channels
  // ==========
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= lpc_pkg::RESP_OKAY;
      ar_have_q <= 1'b0;
      rd_addr <= '0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        rd_addr <= s_axi_araddr;
        ar_have_q <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      if (ar_have_q) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? rd_data : '0;
        s_axi_rresp <= rd_ok ? lpc_pkg::RESP_OKAY : lpc_pkg::RESP_SLVERR;
        ar_have_q <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // lpc_axil_port

// ---- lpc_loopback_ctrl.sv ----
/*
  Loopback path control: control register, automatic remote loopback
  sequencer, loop data-path selection and event interrupt.
  Assumes line and recovered data are bit-rate samples synchronous to aclk,
  and the loop code detectors deliver levels synchronous to aclk.
*/

// Behaviour
// RULE_01: Local loop sends transmit data into receive.
// RULE_02: Remote loop sends recovered data to transmit.
// RULE_03: Remote loop ignores transmit inputs, receive normal.
// RULE_04: Five-second loop-up enters loop, sets info.
// RULE_05: Five-second loop-down leaves loop, clears info.
// RULE_06: Enable falling edge returns sequencer to idle.
// RULE_07: Remote loop is manual OR automatic.
// RULE_08: Analog loop feeds line output to receiver.
// RULE_09: Jitter bypass skips attenuator, backplane clock not. Code ignores the bypass in local loop and on remote-loop transmit.
// RULE_10: Low three bits select error count source.
// RULE_11: Qualification restarts whenever detection drops.
module lpc_loopback_ctrl #(
  parameter int unsigned QUAL_CYCLES = lpc_pkg::QUAL_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [lpc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lpc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic loop_up_detect,
  input wire logic loop_down_detect,
  input wire logic ja_enable,
  input wire lpc_pkg::lpc_pair_type tx_data_in,
  input wire lpc_pkg::lpc_pair_type cdr_data,
  input wire lpc_pkg::lpc_pair_type ja_data_out,
  input wire lpc_pkg::lpc_pair_type rx_line_in,
  output lpc_pkg::lpc_pair_type tx_line_out,
  output lpc_pkg::lpc_pair_type rx_front_in,
  output lpc_pkg::lpc_pair_type ja_data_in,
  output lpc_pkg::lpc_pair_type rx_data_out,
  output logic backplane_clk_use_ja,
  output logic [2:0] err_count_sel,
  output logic remote_loop_active,
  output logic auto_loop_active,
  output logic irq
);

  // ==========
  // Declarations
  // ==========
  logic wr_en;
  lpc_pkg::lpc_wr_type wr;
  logic wr_ok;
  logic [lpc_pkg::ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  logic [7:0] ctrl_q;
  logic [lpc_pkg::EVT_W-1:0] evt_sts_q;
  logic [lpc_pkg::EVT_W-1:0] evt_sts_d;
  logic [lpc_pkg::EVT_W-1:0] evt_mask_q;
  logic [lpc_pkg::EVT_W-1:0] evt_set;
  logic [lpc_pkg::EVT_W-1:0] evt_clr;

  lpc_pkg::lpc_auto_state_type auto_state_q;
  lpc_pkg::lpc_auto_state_type auto_state_d;
  logic auto_en_prev_q;
  logic auto_en;
  logic auto_fall;
  logic up_qualified;
  logic down_qualified;
  logic up_clear;
  logic down_clear;
  logic eff_remote;
  lpc_pkg::lpc_pair_type rx_src;

  function automatic logic addr_known(input logic [lpc_pkg::ADDR_W-1:0] a);
    addr_known = (a == lpc_pkg::CTRL_ADDR) || (a == lpc_pkg::IRQ_STS_ADDR) ||
                 (a == lpc_pkg::IRQ_MASK_ADDR) || (a == lpc_pkg::RX_INFO2_ADDR);
  endfunction

  function automatic logic wr_hit(input logic [lpc_pkg::ADDR_W-1:0] a);
    wr_hit = wr_en && wr.strb[0] && (wr.addr == a);
  endfunction

  // ==========
  // Bus slave
  // ==========
  lpc_axil_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr(wr),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  assign wr_ok = addr_known(wr.addr) && (wr.addr != lpc_pkg::RX_INFO2_ADDR);
  assign rd_ok = addr_known(rd_addr);

  always_comb begin
    rd_data = '0;
    case (rd_addr)
      lpc_pkg::CTRL_ADDR: begin
        rd_data[7:0] = ctrl_q;
      end
      lpc_pkg::IRQ_STS_ADDR: begin
        rd_data[lpc_pkg::EVT_W-1:0] = evt_sts_q;
      end
      lpc_pkg::IRQ_MASK_ADDR: begin
        rd_data[lpc_pkg::EVT_W-1:0] = evt_mask_q;
      end
      lpc_pkg::RX_INFO2_ADDR: begin
        rd_data[lpc_pkg::INFO2_AUTO_LOOP_BIT] = auto_loop_active;
        rd_data[lpc_pkg::INFO2_EFF_REMOTE_BIT] = remote_loop_active;
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  // ==========
  // Control register
  // ==========
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= lpc_pkg::CTRL_RESET;
    end else if (wr_hit(lpc_pkg::CTRL_ADDR)) begin
      ctrl_q <= wr.data[7:0];
    end
  end

  assign auto_en = ctrl_q[lpc_pkg::AUTO_LOOP_BIT];

  // Error count source select is registered once on its way to the counter block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_count_sel <= '0;
    end else begin
      err_count_sel <= ctrl_q[lpc_pkg::ERR_SEL_MSB:lpc_pkg::ERR_SEL_LSB]; // [RULE_10]
    end
  end

  // ==========
  // Automatic remote loopback sequencer
  // ==========
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_en_prev_q <= 1'b0;
    end else begin
      auto_en_prev_q <= auto_en;
    end
  end

  assign auto_fall = auto_en_prev_q && !auto_en; // [RULE_06]

  // Each timer only runs in the state where its code matters
  assign up_clear = !auto_en || (auto_state_q != lpc_pkg::LPC_AUTO_IDLE);
  assign down_clear = !auto_en || (auto_state_q != lpc_pkg::LPC_AUTO_LOOPED);

  lpc_qual_timer #(
    .QUAL_CYCLES(QUAL_CYCLES)
  ) u_up_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(up_clear),
    .detect(loop_up_detect), // [RULE_11]
    .qualified(up_qualified)
  );

  lpc_qual_timer #(
    .QUAL_CYCLES(QUAL_CYCLES)
  ) u_down_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(down_clear),
    .detect(loop_down_detect), // [RULE_11]
    .qualified(down_qualified)
  );

  always_comb begin
    auto_state_d = auto_state_q;
    evt_set = '0;
    case (auto_state_q)
      lpc_pkg::LPC_AUTO_IDLE: begin
        if (auto_en && !auto_fall && up_qualified) begin
          auto_state_d = lpc_pkg::LPC_AUTO_LOOPED; // [RULE_04]
          evt_set[lpc_pkg::EVT_ENTER_BIT] = 1'b1;
        end
      end
      lpc_pkg::LPC_AUTO_LOOPED: begin
        if (auto_fall) begin
          auto_state_d = lpc_pkg::LPC_AUTO_IDLE; // [RULE_06]
        end else if (down_qualified) begin
          auto_state_d = lpc_pkg::LPC_AUTO_IDLE; // [RULE_05]
          evt_set[lpc_pkg::EVT_EXIT_BIT] = 1'b1;
        end
      end
      default: begin
        auto_state_d = lpc_pkg::LPC_AUTO_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_state_q <= lpc_pkg::LPC_AUTO_IDLE;
    end else begin
      auto_state_q <= auto_state_d;
    end
  end

  assign eff_remote = ctrl_q[lpc_pkg::REMOTE_LOOP_BIT] || (auto_state_q == lpc_pkg::LPC_AUTO_LOOPED); // [RULE_07]

  // Info bit follows the sequencer state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_loop_active <= 1'b0;
      remote_loop_active <= 1'b0;
    end else begin
      auto_loop_active <= (auto_state_q == lpc_pkg::LPC_AUTO_LOOPED); // [RULE_04] [RULE_05]
      remote_loop_active <= eff_remote;
    end
  end

  // ==========
  // Events and interrupt
  // ==========
  assign evt_clr = wr_hit(lpc_pkg::IRQ_STS_ADDR) ? wr.data[lpc_pkg::EVT_W-1:0] : '0;
  assign evt_sts_d = (evt_sts_q & ~evt_clr) | evt_set;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_sts_q <= lpc_pkg::EVT_RESET;
    end else begin
      evt_sts_q <= evt_sts_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_mask_q <= lpc_pkg::EVT_RESET;
    end else if (wr_hit(lpc_pkg::IRQ_MASK_ADDR)) begin
      evt_mask_q <= wr.data[lpc_pkg::EVT_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_sts_d & evt_mask_q);
    end
  end

  // ==========
  // Data paths
  // ==========
  // Receive source before attenuation: looped transmit data or recovered data
  assign rx_src = ctrl_q[lpc_pkg::LOCAL_LOOP_BIT] ? tx_data_in : cdr_data; // [RULE_01]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_line_out <= '0;
      rx_front_in <= '0;
      ja_data_in <= '0;
      rx_data_out <= '0;
      backplane_clk_use_ja <= 1'b0;
    end else begin
      // Transmit inputs are dropped while remote loop owns the line
      if (eff_remote) begin
        tx_line_out <= ja_enable ? ja_data_out : cdr_data; // [RULE_02] [RULE_03]
      end else begin
        tx_line_out <= tx_data_in; // [RULE_01]
      end
      // In analog loop the receiver front end hears our own line driver, not the line
      rx_front_in <= ctrl_q[lpc_pkg::ANALOG_LOOP_BIT] ? tx_line_out : rx_line_in; // [RULE_08]
      ja_data_in <= eff_remote ? cdr_data : rx_src; // [RULE_02]
      if (ctrl_q[lpc_pkg::LOCAL_LOOP_BIT]) begin
        rx_data_out <= ja_enable ? ja_data_out : rx_src; // [RULE_01]
      end else if (ja_enable && !ctrl_q[lpc_pkg::JA_BYPASS_BIT]) begin
        rx_data_out <= ja_data_out; // [RULE_03]
      end else begin
        rx_data_out <= cdr_data; // [RULE_09]
      end
      backplane_clk_use_ja <= ja_enable; // [RULE_09]
    end
  end

endmodule // lpc_loopback_ctrl

// ---- lpc_loopback_ctrl_sva.sv ----
/*
  Assertion checker of the loopback path control block, watching its ports.
  Assumes one clock domain and a reduced qualification count in simulation.
*/
module lpc_loopback_ctrl_sva #(
  parameter int unsigned QUAL_CYCLES = lpc_pkg::QUAL_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [lpc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic loop_up_detect,
  input wire logic ja_enable,
  input wire lpc_pkg::lpc_pair_type tx_data_in,
  input wire lpc_pkg::lpc_pair_type cdr_data,
  input wire lpc_pkg::lpc_pair_type ja_data_out,
  input wire lpc_pkg::lpc_pair_type rx_line_in,
  input wire lpc_pkg::lpc_pair_type tx_line_out,
  input wire lpc_pkg::lpc_pair_type rx_front_in,
  input wire logic backplane_clk_use_ja,
  input wire logic [2:0] err_count_sel,
  input wire logic remote_loop_active,
  input wire logic auto_loop_active
);
  // ==========
  // Helper logic
  logic [31:0] up_run_q;
  logic [2:0] sel_q;
  logic ctrl_take;
  assign ctrl_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr == lpc_pkg::CTRL_ADDR && s_axi_wstrb[0];
  // Length of the current unbroken loop-up run
  always_ff @(posedge aclk) begin
    if (!aresetn || !loop_up_detect) begin
      up_run_q <= '0;
    end else begin
      up_run_q <= up_run_q + 32'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (ctrl_take) begin
      sel_q <= s_axi_wdata[2:0];
    end
  end
  // ==========
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bus_write_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  bus_read_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while response pending");
  sel_update_a: assert property (ctrl_take |=> ##[1:3] err_count_sel == sel_q)
    else $error("error count select not updated");
  auto_enter_a: assert property ($rose(auto_loop_active) |-> $past(up_run_q, 2) >= QUAL_CYCLES)
    else $error("auto loop entered before full qualification");
  remote_or_a: assert property (auto_loop_active |-> remote_loop_active || $past(remote_loop_active))
    else $error("auto loop without remote loop");
  remote_tx_a: assert property (remote_loop_active && $past(remote_loop_active) |->
    tx_line_out == ($past(ja_enable) ? $past(ja_data_out) : $past(cdr_data)))
    else $error("remote loop transmit data wrong");
  normal_tx_a: assert property ($past(aresetn) && !remote_loop_active && !$past(remote_loop_active) |->
    tx_line_out == $past(tx_data_in))
    else $error("transmit data not passed through");
  analog_rx_a: assert property ($past(aresetn) |->
    rx_front_in == $past(rx_line_in) || rx_front_in == $past(tx_line_out))
    else $error("receiver front end fed from wrong source");
  bp_clock_a: assert property ($past(aresetn) |-> backplane_clk_use_ja == $past(ja_enable))
    else $error("backplane clock source wrong");
endmodule // lpc_loopback_ctrl_sva

// ---- lpc_line_model.sv ----
/*
  Line-side model: loop code detector levels and line sample streams.
  Assumes the bench picks the loop code on the line through code_sel.
*/
module lpc_line_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] code_sel,
  output logic loop_up_detect,
  output logic loop_down_detect,
  output lpc_pkg::lpc_pair_type cdr_data,
  output lpc_pkg::lpc_pair_type ja_data_out,
  output lpc_pkg::lpc_pair_type rx_line_in
);
  logic [15:0] lfsr_q;
  // ==========
  // Line samples change every cycle so a stale path shows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_q <= 16'h0001;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end
  assign cdr_data = lfsr_q[1:0];
  assign ja_data_out = lfsr_q[5:4];
  assign rx_line_in = lfsr_q[9:8];
  // ==========
  // Loop code detectors
  assign loop_up_detect = code_sel == 2'h1;
  assign loop_down_detect = code_sel == 2'h2;
endmodule // lpc_line_model

// ---- loopback_path_control_tb.sv ----
/*
  Self-checking bench of the loopback path control block with a line model.
  Assumes the package, the checker and the line model are compiled first.
*/
module loopback_path_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned QUAL = 20;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, m;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, code_sel, ok, err;
  logic loop_up_detect, loop_down_detect, ja_enable, backplane_clk_use_ja, remote_loop_active, auto_loop_active, irq;
  logic [2:0] err_count_sel;
  lpc_pkg::lpc_pair_type tx_data_in, cdr_data, ja_data_out, rx_line_in, tx_line_out, rx_front_in;
  lpc_pkg::lpc_pair_type ja_data_in, rx_data_out, pt, pc, pj, pl, po;
  logic [7:0] modes [5] = '{8'h00, 8'h80, 8'h40, 8'h10, 8'h08};
  logic [33:0] bq[$], rq[$];
  int miscompares, checks, cyc, n;
  lpc_loopback_ctrl #(.QUAL_CYCLES(QUAL)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .loop_up_detect, .loop_down_detect, .ja_enable, .tx_data_in, .cdr_data, .ja_data_out, .rx_line_in,
    .tx_line_out, .rx_front_in, .ja_data_in, .rx_data_out, .backplane_clk_use_ja, .err_count_sel,
    .remote_loop_active, .auto_loop_active, .irq);
  lpc_line_model u_line (.aclk, .aresetn, .code_sel, .loop_up_detect, .loop_down_detect, .cdr_data,
    .ja_data_out, .rx_line_in);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // ==========
  // Comparison, report and bus tasks
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    bq.push_back({32'h0, e});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    rq.push_back({e, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_auto(input logic v, output int k);
    k = 0;
    while (auto_loop_active !== v && k < 200) begin
      @(posedge aclk);
      k++;
    end
  endtask
  // ==========
  // Response monitor, stimulus of transmit data and timeout
  always @(posedge aclk) begin
    tx_data_in <= 2'($urandom);
    cyc++;
    if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'hf294));
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ja_enable} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, code_sel} = '0;
    ok = lpc_pkg::RESP_OKAY;
    err = lpc_pkg::RESP_SLVERR;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(lpc_pkg::CTRL_ADDR, {24'h0, lpc_pkg::CTRL_RESET}, ok);
    rd(lpc_pkg::IRQ_STS_ADDR, 32'h0, ok);
    rd(lpc_pkg::IRQ_MASK_ADDR, 32'h0, ok);
    rd(lpc_pkg::RX_INFO2_ADDR, 32'h0, ok);
    rd(8'h3c, 32'h0, err);
    wr(lpc_pkg::RX_INFO2_ADDR, 32'hff, 4'hf, err);
    wr(8'h3c, 32'hff, 4'hf, err);
    $display("test reset and refusals done");
    for (int i = 0; i < 6; i++) begin
      m = 8'($urandom);
      wr(lpc_pkg::CTRL_ADDR, {24'hffffff, m}, 4'hf, ok);
      rd(lpc_pkg::CTRL_ADDR, {24'h0, m}, ok);
      chk(34'(err_count_sel), 34'(m[2:0]));
    end
    wr(lpc_pkg::CTRL_ADDR, 32'h7, 4'he, ok);
    rd(lpc_pkg::CTRL_ADDR, {24'h0, m}, ok);
    $display("test control register done");
    for (int i = 0; i < 10; i++) begin
      m = modes[i / 2];
      @(posedge aclk);
      ja_enable <= i[0];
      wr(lpc_pkg::CTRL_ADDR, {24'h0, m}, 4'hf, ok);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      {pt, pc, pj, pl, po} = {tx_data_in, cdr_data, ja_data_out, rx_line_in, tx_line_out};
      @(negedge aclk);
      chk(34'(tx_line_out), 34'(m[6] ? (i[0] ? pj : pc) : pt));
      chk(34'(rx_front_in), 34'(m[4] ? po : pl));
      chk(34'(remote_loop_active), 34'(m[6]));
      chk(34'(ja_data_in), 34'(m[7] ? pt : pc));
      chk(34'(rx_data_out), 34'(m[7] ? (i[0] ? pj : pt) : ((i[0] && !m[3]) ? pj : pc)));
    end
    $display("test data paths done");
    @(posedge aclk);
    wr(lpc_pkg::IRQ_MASK_ADDR, 32'h1, 4'hf, ok);
    wr(lpc_pkg::CTRL_ADDR, 32'h20, 4'hf, ok);
    code_sel <= 2'h1;
    repeat (QUAL - 1) @(posedge aclk);
    code_sel <= 2'h0;
    repeat (6) @(posedge aclk);
    chk(34'(auto_loop_active), 34'h0);
    code_sel <= 2'h1;
    wait_auto(1'b1, n);
    code_sel <= 2'h0;
    chk(34'(n inside {[QUAL:QUAL + 6]}), 34'h1);
    rd(lpc_pkg::RX_INFO2_ADDR, 32'h3, ok);
    rd(lpc_pkg::IRQ_STS_ADDR, 32'h1, ok);
    chk(34'(irq), 34'h1);
    wr(lpc_pkg::IRQ_STS_ADDR, 32'h1, 4'hf, ok);
    rd(lpc_pkg::IRQ_STS_ADDR, 32'h0, ok);
    chk(34'(irq), 34'h0);
    code_sel <= 2'h2;
    wait_auto(1'b0, n);
    code_sel <= 2'h0;
    chk(34'(n inside {[QUAL:QUAL + 6]}), 34'h1);
    rd(lpc_pkg::RX_INFO2_ADDR, 32'h0, ok);
    rd(lpc_pkg::IRQ_STS_ADDR, 32'h2, ok);
    chk(34'(irq), 34'h0);
    wr(lpc_pkg::IRQ_STS_ADDR, 32'h2, 4'hf, ok);
    $display("test automatic loop done");
    code_sel <= 2'h1;
    wait_auto(1'b1, n);
    code_sel <= 2'h0;
    wr(lpc_pkg::CTRL_ADDR, 32'h0, 4'hf, ok);
    wait_auto(1'b0, n);
    chk(34'(n <= 5), 34'h1);
    rd(lpc_pkg::IRQ_STS_ADDR, 32'h1, ok);
    $display("test automatic loop reset done");
    final_report();
  end
endmodule // loopback_path_control_tb
bind lpc_loopback_ctrl lpc_loopback_ctrl_sva #(.QUAL_CYCLES(QUAL_CYCLES)) u_sva (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .loop_up_detect, .ja_enable, .tx_data_in, .cdr_data,
  .ja_data_out, .rx_line_in, .tx_line_out, .rx_front_in, .backplane_clk_use_ja, .err_count_sel,
  .remote_loop_active, .auto_loop_active);
